/* hw/dbs_pkg.sv */
// Shared constants for the burst-of-four common-I/O memory port and its controller
package dbs_pkg;
   // Burst length and default geometry
   localparam int BURST_LEN = 4;
   localparam int DQ_W_DEF  = 36;
   localparam int LANES_DEF = 4;
   localparam int SA_W_DEF  = 6;
   // Controller phase within one link clock period (four clk cycles)
   localparam logic [1:0] PH_MID_HI = 2'h0;
   localparam logic [1:0] PH_FALL   = 2'h1;
   localparam logic [1:0] PH_MID_LO = 2'h2;
   localparam logic [1:0] PH_RISE   = 2'h3;
   // Least spacing, in link clock periods, before the next command
   localparam logic [2:0] GAP_AFTER_RD_RD = 3'h2;
   localparam logic [2:0] GAP_AFTER_RD_WR = 3'h6;
   localparam logic [2:0] GAP_AFTER_WR    = 3'h2;
endpackage

/* hw/dbs_link_if.sv */
// Link between the memory controller and the memory port
`timescale 1ns/1ps
`default_nettype none
interface dbs_link_if #(
   parameter int DQ_W  = dbs_pkg::DQ_W_DEF,
   parameter int LANES = dbs_pkg::LANES_DEF,
   parameter int SA_W  = dbs_pkg::SA_W_DEF
);
   logic             k;
   logic             k_n;
   logic [SA_W-1:0]  burst_start_address;
   logic             new_address_strobe_n;
   logic             read_select;
   logic [LANES-1:0] byte_lane_write_n;
   logic [DQ_W-1:0]  ctl_dq_o;
   logic             ctl_dq_oe;
   logic [DQ_W-1:0]  dev_dq_o;
   logic             dev_dq_oe;
   logic [DQ_W-1:0]  dq;
   logic             echo_strobe;
   logic             echo_strobe_n;

   // Shared bus level; an undriven bus reads as zero
   assign dq = ctl_dq_oe ? ctl_dq_o : (dev_dq_oe ? dev_dq_o : {DQ_W{1'b0}});

   modport ctl (
      output k, k_n, burst_start_address, new_address_strobe_n, read_select,
      output byte_lane_write_n, ctl_dq_o, ctl_dq_oe,
      input  dq
   );
   modport dev (
      input  k, k_n, burst_start_address, new_address_strobe_n, read_select,
      input  byte_lane_write_n, dq,
      output dev_dq_o, dev_dq_oe, echo_strobe, echo_strobe_n
   );
endinterface
`default_nettype wire

/* hw/dbs_sram_dev.sv */
// Burst-of-four double-data-rate common-I/O memory port, device end
`timescale 1ns/1ps
`default_nettype none
module dbs_sram_dev #(
   parameter int DQ_W  = dbs_pkg::DQ_W_DEF,
   parameter int LANES = dbs_pkg::LANES_DEF,
   parameter int SA_W  = dbs_pkg::SA_W_DEF
) (
   // Link to the controller
   dbs_link_if.dev   link,
   // Local control
   input wire logic  ce,
   input wire logic  reset
);
   localparam int LW    = DQ_W / LANES;
   localparam int DEPTH = 2 ** (SA_W + 2);

   // Refuse geometries the lane slicing cannot serve
   if (DQ_W % LANES != 0 || SA_W < 1 || LANES < 1) begin : g_bad
      $error("dbs_sram_dev: unsupported parameters");
   end

   // Replace enabled byte lanes of a word
   function automatic logic [DQ_W-1:0] lane_merge(input logic [DQ_W-1:0]  old_w,
                                                  input logic [DQ_W-1:0]  new_w,
                                                  input logic [LANES-1:0] en);
      logic [DQ_W-1:0] r;
      r = old_w;
      for (int l = 0; l < LANES; l++) begin
         if (en[l]) begin
            r[l*LW +: LW] = new_w[l*LW +: LW];
         end
      end
      return r;
   endfunction

   // Word index of burst word off
   function automatic logic [SA_W+1:0] word_index(input logic [SA_W-1:0] sa,
                                                  input logic [1:0]      off);
      return {sa, off};
   endfunction

   logic                         rst_s1_reg;
   logic                         rst_s2_reg;
   logic                         cmd;
   logic                         rd_cmd;
   logic                         wr_cmd;
   logic [3:0]                   rd_sh_reg;
   logic [2:0]                   wr_sh_reg;
   logic [SA_W-1:0]              ra_reg;
   logic [SA_W-1:0]              wa_reg;
   logic [SA_W-1:0]              wa_hold_reg;
   logic [2:0][DQ_W-1:0]         in_d_reg;
   logic [2:0][LANES-1:0]        in_m_reg;
   logic [DQ_W-1:0]              hold_d_reg;
   logic [LANES-1:0]             hold_m_reg;
   logic                         a_v_reg;
   logic [SA_W-1:0]              a_sa_reg;
   logic [3:0][DQ_W-1:0]         a_d_reg;
   logic [3:0][LANES-1:0]        a_m_reg;
   logic                         b_v_reg;
   logic [SA_W-1:0]              b_sa_reg;
   logic [3:0][DQ_W-1:0]         b_d_reg;
   logic [3:0][LANES-1:0]        b_m_reg;
   logic [DQ_W-1:0]              mem [DEPTH];
   logic [3:0][DQ_W-1:0]         look;
   logic [3:0][DQ_W-1:0]         rdata_reg;
   logic                         push;
   logic [DQ_W-1:0]              q_k_reg;
   logic                         oe_k_reg;
   logic [DQ_W-1:0]              q_kn_reg;
   logic                         oe_kn_reg;

   // Reset arrives from another domain, so it is resynchronised first
   always_ff @(posedge link.k) begin
      rst_s1_reg <= reset;
      rst_s2_reg <= rst_s1_reg;
   end

   // Command decode on the true clock edge
   assign cmd    = ce && !rst_s2_reg && !link.new_address_strobe_n;
   assign rd_cmd = cmd && link.read_select;
   assign wr_cmd = cmd && !link.read_select;
   assign push   = ce && !rst_s2_reg && wr_sh_reg[2];

   // Burst progress; an idle cycle never clears a burst in flight
   always_ff @(posedge link.k) begin
      if (rst_s2_reg) begin
         rd_sh_reg <= 4'h0;
         wr_sh_reg <= 3'h0;
      end else if (ce) begin
         rd_sh_reg <= {rd_sh_reg[2:0], rd_cmd};
         wr_sh_reg <= {wr_sh_reg[1:0], wr_cmd};
      end
   end

   // Address registers; the write address is held until its burst completes
   always_ff @(posedge link.k) begin
      if (ce) begin
         if (rd_cmd) begin
            ra_reg <= link.burst_start_address;
         end
         if (wr_cmd) begin
            wa_reg <= link.burst_start_address;
         end
         if (wr_sh_reg[0]) begin
            wa_hold_reg <= wa_reg;
         end
      end
   end

   // Complement edge capture of the second and fourth write words
   always_ff @(posedge link.k_n) begin
      if (ce) begin
         hold_d_reg <= link.dq;
         hold_m_reg <= ~link.byte_lane_write_n;
      end
   end

   // True edge capture of write words, lanes taken with their word
   always_ff @(posedge link.k) begin
      if (ce) begin
         if (wr_sh_reg[0]) begin
            in_d_reg[0] <= link.dq;
            in_m_reg[0] <= ~link.byte_lane_write_n;
         end
         if (wr_sh_reg[1]) begin
            in_d_reg[1] <= hold_d_reg;
            in_m_reg[1] <= hold_m_reg;
            in_d_reg[2] <= link.dq;
            in_m_reg[2] <= ~link.byte_lane_write_n;
         end
      end
   end

   // Two-deep write buffer: newest in a, previous in b
   always_ff @(posedge link.k) begin
      if (rst_s2_reg) begin
         a_v_reg <= 1'b0;
         b_v_reg <= 1'b0;
      end else if (push) begin
         b_v_reg  <= a_v_reg;
         b_sa_reg <= a_sa_reg;
         b_d_reg  <= a_d_reg;
         b_m_reg  <= a_m_reg;
         a_v_reg  <= 1'b1;
         a_sa_reg <= wa_hold_reg;
         a_d_reg  <= {hold_d_reg, in_d_reg[2], in_d_reg[1], in_d_reg[0]};
         a_m_reg  <= {hold_m_reg, in_m_reg[2], in_m_reg[1], in_m_reg[0]};
      end
   end

   // Older buffered burst reaches the array when a further write completes
   always_ff @(posedge link.k) begin
      if (push && b_v_reg) begin
         for (int i = 0; i < dbs_pkg::BURST_LEN; i++) begin
            mem[word_index(b_sa_reg, 2'(i))] <=
               lane_merge(mem[word_index(b_sa_reg, 2'(i))], b_d_reg[i], b_m_reg[i]);
         end
      end
   end

   // Read lookup: array overlaid by the older then the newer buffered burst
   always_comb begin
      for (int i = 0; i < dbs_pkg::BURST_LEN; i++) begin
         look[i] = mem[word_index(ra_reg, 2'(i))];
         if (b_v_reg && b_sa_reg == ra_reg) begin
            look[i] = lane_merge(look[i], b_d_reg[i], b_m_reg[i]);
         end
         if (a_v_reg && a_sa_reg == ra_reg) begin
            look[i] = lane_merge(look[i], a_d_reg[i], a_m_reg[i]);
         end
      end
   end

   // Read words fetched two edges after the command
   always_ff @(posedge link.k) begin
      if (ce && rd_sh_reg[1]) begin
         rdata_reg <= look;
      end
   end

   // True edge launches of the second and fourth read words
   always_ff @(posedge link.k) begin
      if (rst_s2_reg) begin
         oe_k_reg <= 1'b0;
      end else if (ce) begin
         oe_k_reg <= rd_sh_reg[2] || rd_sh_reg[3];
         if (rd_sh_reg[2]) begin
            q_k_reg <= rdata_reg[1];
         end else if (rd_sh_reg[3]) begin
            q_k_reg <= rdata_reg[3];
         end
      end
   end

   // Complement edge launches of the first and third read words
   always_ff @(posedge link.k_n) begin
      if (rst_s2_reg) begin
         oe_kn_reg <= 1'b0;
      end else if (ce) begin
         oe_kn_reg <= rd_sh_reg[2] || rd_sh_reg[3];
         if (rd_sh_reg[2]) begin
            q_kn_reg <= rdata_reg[0];
         end else if (rd_sh_reg[3]) begin
            q_kn_reg <= rdata_reg[2];
         end
      end
   end

   // The latest launching edge picks the register on the bus
   assign link.dev_dq_o  = link.k ? q_k_reg : q_kn_reg;
   assign link.dev_dq_oe = link.k ? oe_k_reg : oe_kn_reg;

   // Echo clocks follow the input pair, so they edge-align with read data
   assign link.echo_strobe   = link.k;
   assign link.echo_strobe_n = link.k_n;
endmodule
`default_nettype wire

/* hw/dbs_sram_ctl.sv */
// Memory controller end: link clock generation, command issue and burst transfer
`timescale 1ns/1ps
`default_nettype none
module dbs_sram_ctl #(
   parameter int DQ_W  = dbs_pkg::DQ_W_DEF,
   parameter int LANES = dbs_pkg::LANES_DEF,
   parameter int SA_W  = dbs_pkg::SA_W_DEF
) (
   // Clock and control
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   ce,
   // Request
   input  wire logic                   req_valid,
   output logic                        req_ready,
   input  wire logic                   req_write,
   input  wire logic [SA_W-1:0]        req_addr,
   input  wire logic [3:0][DQ_W-1:0]   req_wdata,
   input  wire logic [3:0][LANES-1:0]  req_wen,
   // Read answer
   output logic                        rsp_valid,
   output logic [3:0][DQ_W-1:0]        rsp_rdata,
   // Link to the memory
   dbs_link_if.ctl                     link
);
   // Refuse geometries the lane slicing cannot serve
   if (DQ_W % LANES != 0 || SA_W < 1 || LANES < 1) begin : g_bad
      $error("dbs_sram_ctl: unsupported parameters");
   end

   logic [1:0]            ph_reg;
   logic [2:0]            rd_gap_reg;
   logic [2:0]            wr_gap_reg;
   logic [4:0]            rd_sh_reg;
   logic [2:0]            wr_sh_reg;
   logic [3:0][DQ_W-1:0]  pend_d_reg;
   logic [3:0][LANES-1:0] pend_m_reg;
   logic [3:0][DQ_W-1:0]  act_d_reg;
   logic [3:0][LANES-1:0] act_m_reg;
   logic [DQ_W-1:0]       d1_reg;
   logic [DQ_W-1:0]       d2_reg;
   logic [2:0][DQ_W-1:0]  col_reg;
   logic                  mid_hi;
   logic                  mid_lo;
   logic                  take;

   assign mid_hi    = ce && ph_reg == dbs_pkg::PH_MID_HI;
   assign mid_lo    = ce && ph_reg == dbs_pkg::PH_MID_LO;
   assign req_ready = mid_lo &&
                      (req_write ? wr_gap_reg == 3'h0 : rd_gap_reg == 3'h0);
   assign take      = req_valid && req_ready;

   // Link clock pair: four clk cycles per period, outputs change mid-phase
   always_ff @(posedge clk) begin
      if (reset) begin
         ph_reg   <= dbs_pkg::PH_MID_LO;
         link.k   <= 1'b0;
         link.k_n <= 1'b1;
      end else if (ce) begin
         ph_reg <= ph_reg + 2'h1;
         if (ph_reg == dbs_pkg::PH_RISE) begin
            link.k   <= 1'b1;
            link.k_n <= 1'b0;
         end else if (ph_reg == dbs_pkg::PH_FALL) begin
            link.k   <= 1'b0;
            link.k_n <= 1'b1;
         end
      end
   end

   // Command issue, set up a quarter period (one clk cycle) before the true edge
   always_ff @(posedge clk) begin
      if (reset) begin
         link.new_address_strobe_n <= 1'b1;
         link.read_select          <= 1'b0;
         link.burst_start_address  <= {SA_W{1'b0}};
      end else if (mid_lo) begin
         link.new_address_strobe_n <= !take;
         if (take) begin
            link.read_select         <= !req_write;
            link.burst_start_address <= req_addr;
            pend_d_reg               <= req_wdata;
            pend_m_reg               <= req_wen;
         end
      end
   end

   // Spacing counters; a read holds off writes until the bus has floated
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_gap_reg <= 3'h0;
         wr_gap_reg <= 3'h0;
      end else if (take) begin
         rd_gap_reg <= req_write ? dbs_pkg::GAP_AFTER_WR : dbs_pkg::GAP_AFTER_RD_RD;
         wr_gap_reg <= req_write ? dbs_pkg::GAP_AFTER_WR : dbs_pkg::GAP_AFTER_RD_WR;
      end else if (ce && ph_reg == dbs_pkg::PH_RISE) begin
         if (rd_gap_reg != 3'h0) begin
            rd_gap_reg <= rd_gap_reg - 3'h1;
         end
         if (wr_gap_reg != 3'h0) begin
            wr_gap_reg <= wr_gap_reg - 3'h1;
         end
      end
   end

   // Burst progress, stepped at each true edge
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_sh_reg <= 5'h00;
         wr_sh_reg <= 3'h0;
      end else if (ce && ph_reg == dbs_pkg::PH_RISE) begin
         rd_sh_reg <= {rd_sh_reg[3:0], !link.new_address_strobe_n && link.read_select};
         wr_sh_reg <= {wr_sh_reg[1:0], !link.new_address_strobe_n && !link.read_select};
      end
   end

   // Write data and lanes, first word one period after the command
   always_ff @(posedge clk) begin
      if (reset) begin
         link.ctl_dq_oe         <= 1'b0;
         link.ctl_dq_o          <= {DQ_W{1'b0}};
         link.byte_lane_write_n <= {LANES{1'b1}};
      end else if (mid_lo) begin
         if (wr_sh_reg[0]) begin
            act_d_reg              <= pend_d_reg;
            act_m_reg              <= pend_m_reg;
            link.ctl_dq_o          <= pend_d_reg[0];
            link.byte_lane_write_n <= ~pend_m_reg[0];
            link.ctl_dq_oe         <= 1'b1;
         end else if (wr_sh_reg[1]) begin
            link.ctl_dq_o          <= act_d_reg[2];
            link.byte_lane_write_n <= ~act_m_reg[2];
         end else begin
            link.ctl_dq_oe         <= 1'b0;
            link.byte_lane_write_n <= {LANES{1'b1}};
         end
      end else if (mid_hi) begin
         if (wr_sh_reg[1]) begin
            link.ctl_dq_o          <= act_d_reg[1];
            link.byte_lane_write_n <= ~act_m_reg[1];
         end else if (wr_sh_reg[2]) begin
            link.ctl_dq_o          <= act_d_reg[3];
            link.byte_lane_write_n <= ~act_m_reg[3];
         end
      end
   end

   // Read bus passes two flip-flops before use
   always_ff @(posedge clk) begin
      if (ce) begin
         d1_reg <= link.dq;
         d2_reg <= d1_reg;
      end
   end

   // Read words collected mid-phase, answer pulsed with the fourth word
   always_ff @(posedge clk) begin
      if (reset) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= {4*DQ_W{1'b0}};
      end else if (ce) begin
         rsp_valid <= mid_lo && rd_sh_reg[4];
         if (mid_hi && rd_sh_reg[3]) begin
            col_reg[0] <= d2_reg;
         end
         if (mid_lo && rd_sh_reg[3]) begin
            col_reg[1] <= d2_reg;
         end
         if (mid_hi && rd_sh_reg[4]) begin
            col_reg[2] <= d2_reg;
         end
         if (mid_lo && rd_sh_reg[4]) begin
            rsp_rdata <= {d2_reg, col_reg[2], col_reg[1], col_reg[0]};
         end
      end
   end
endmodule
`default_nettype wire

/* testbench/dbs_sram_sva.sv */
// Concurrent checks on the link between the memory controller and the memory port
`timescale 1ns/1ps
`default_nettype none
module dbs_sram_sva #(
   parameter int DQ_W  = dbs_pkg::DQ_W_DEF,
   parameter int LANES = dbs_pkg::LANES_DEF,
   parameter int SA_W  = dbs_pkg::SA_W_DEF
) (
   // Sampling clock and reset
   input wire logic             clk,
   input wire logic             reset,
   // Link signals
   input wire logic             k,
   input wire logic             k_n,
   input wire logic [SA_W-1:0]  burst_start_address,
   input wire logic             new_address_strobe_n,
   input wire logic             read_select,
   input wire logic [LANES-1:0] byte_lane_write_n,
   input wire logic             ctl_dq_oe,
   input wire logic             dev_dq_oe,
   input wire logic             echo_strobe,
   input wire logic             echo_strobe_n
);
   default clocking dflt_cb @(posedge clk); endclocking
   default disable iff (reset);

   logic        k_q;
   logic [16:0] rd_hist;
   logic [16:0] wr_hist;

   // Previous level of the true clock, to spot its rises
   always_ff @(posedge clk) begin
      k_q <= k;
   end

   // Command history, newest in bit 0; fixes when each end may drive the bus
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_hist <= '0;
         wr_hist <= '0;
      end else begin
         rd_hist <= {rd_hist[15:0], k & ~k_q & ~new_address_strobe_n & read_select};
         wr_hist <= {wr_hist[15:0], k & ~k_q & ~new_address_strobe_n & ~read_select};
      end
   end

   echo_track_a: assert property (echo_strobe == k && echo_strobe_n == k_n && k_n == ~k)
      else $error("echo clocks do not follow the input clocks");
   dev_window_a: assert property (dev_dq_oe == (|rd_hist[16:9]))
      else $error("memory drives the bus outside its read words");
   ctl_window_a: assert property (ctl_dq_oe == (|wr_hist[9:2]))
      else $error("write data window off its place");
   bus_clash_a: assert property (!(dev_dq_oe && ctl_dq_oe))
      else $error("both ends drive the bus");
   lanes_idle_a: assert property (!ctl_dq_oe |-> &byte_lane_write_n)
      else $error("byte lanes active without write data");
   cmd_spacing_a: assert property ($rose(k) && !new_address_strobe_n |->
      ##4 new_address_strobe_n)
      else $error("commands on adjacent clock rises");
   strobe_len_a: assert property ($fell(new_address_strobe_n) |->
      (!new_address_strobe_n)[*4] ##1 new_address_strobe_n)
      else $error("load strobe not one clock period long");
   addr_hold_a: assert property (!new_address_strobe_n &&
      !$past(new_address_strobe_n) |-> $stable(burst_start_address) && $stable(read_select))
      else $error("address or direction moved under the strobe");
   turn_gap_a: assert property ($rose(ctl_dq_oe) |->
      !$past(dev_dq_oe, 1) && !$past(dev_dq_oe, 4))
      else $error("write data without a floating cycle");

   // Main traffic shapes
   cover property (rd_hist[0]);
   cover property (wr_hist[0]);
   cover property (wr_hist[8] && rd_hist[0]);
   cover property (rd_hist[8] && rd_hist[0]);
endmodule
`default_nettype wire

/* testbench/ddr_burst4_cio_sram_port_tb_top.sv */
// Self-checking bench: controller and memory port joined over the link
`timescale 1ns/1ps
`default_nettype none
module ddr_burst4_cio_sram_port_tb_top;
   localparam int DQ_W  = dbs_pkg::DQ_W_DEF;
   localparam int LANES = dbs_pkg::LANES_DEF;
   localparam int SA_W  = dbs_pkg::SA_W_DEF;
   localparam int LW    = DQ_W / LANES;
   // Take to answer in clk cycles: command rise, 2.5-period launch, last word, two sync stages
   localparam int RD_LAT = 20;

   logic                  clk;
   logic                  reset;
   logic                  dev_reset;
   logic                  req_valid;
   logic                  req_ready;
   logic                  req_write;
   logic                  rsp_valid;
   logic [SA_W-1:0]       req_addr;
   logic [3:0][DQ_W-1:0]  req_wdata;
   logic [3:0][DQ_W-1:0]  rsp_rdata;
   logic [3:0][DQ_W-1:0]  exp_b;
   logic [3:0][LANES-1:0] req_wen;
   logic [DQ_W-1:0]       mem [(2 ** SA_W) * 4];
   logic [3:0][DQ_W-1:0]  rd_exp_q [$];
   logic [DQ_W-1:0]       wd_q [$];
   logic [LANES-1:0]      wl_q [$];
   int                    rd_cyc_q [$];
   int                    error_cnt;
   int                    n_tests;
   int                    cyc = 0;

   dbs_link_if i_dbs_link_if ();
   dbs_sram_ctl i_dbs_sram_ctl (.clk(clk), .reset(reset), .ce(1'b1), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_wen(req_wen), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .link(i_dbs_link_if.ctl));
   dbs_sram_dev i_dbs_sram_dev (.link(i_dbs_link_if.dev), .ce(1'b1), .reset(dev_reset));
   dbs_sram_sva i_dbs_sram_sva (.clk(clk), .reset(dev_reset), .k(i_dbs_link_if.k),
      .k_n(i_dbs_link_if.k_n), .burst_start_address(i_dbs_link_if.burst_start_address),
      .new_address_strobe_n(i_dbs_link_if.new_address_strobe_n),
      .read_select(i_dbs_link_if.read_select),
      .byte_lane_write_n(i_dbs_link_if.byte_lane_write_n),
      .ctl_dq_oe(i_dbs_link_if.ctl_dq_oe), .dev_dq_oe(i_dbs_link_if.dev_dq_oe),
      .echo_strobe(i_dbs_link_if.echo_strobe), .echo_strobe_n(i_dbs_link_if.echo_strobe_n));

   // Free-running system clock and cycle count
   always #10 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   task automatic tally_and_finish();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [DQ_W-1:0] seen, input logic [DQ_W-1:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Only enabled lanes replace their bytes
   function automatic logic [DQ_W-1:0] merge(logic [DQ_W-1:0] old, logic [DQ_W-1:0] nw,
                                             logic [LANES-1:0] en);
      for (int l = 0; l < LANES; l++) begin
         if (en[l]) begin
            old[l*LW +: LW] = nw[l*LW +: LW];
         end
      end
      return old;
   endfunction

   function automatic logic [3:0][DQ_W-1:0] rnd_b();
      logic [3:0][DQ_W-1:0] d;
      for (int w = 0; w < 4; w++) begin
         d[w] = DQ_W'({$urandom(), $urandom()});
      end
      return d;
   endfunction

   // One request, held until taken; the model is updated at the take
   task automatic issue(input logic wr, input logic [SA_W-1:0] a,
                        input logic [3:0][DQ_W-1:0] d, input logic [3:0][LANES-1:0] en);
      int i;
      logic [3:0][DQ_W-1:0] e;
      @(negedge clk);
      req_valid = 1'b1;
      req_write = wr;
      req_addr  = a;
      req_wdata = d;
      req_wen   = en;
      #1;
      for (i = 0; i < 64 && req_ready !== 1'b1; i++) begin
         @(negedge clk);
         #1;
      end
      if (i == 64) begin
         error_cnt++;
         tally_and_finish();
      end
      @(posedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      for (int w = 0; w < 4; w++) begin
         e[w] = mem[int'(a) * 4 + w];
         if (wr) begin
            mem[int'(a) * 4 + w] = merge(e[w], d[w], en[w]);
            wd_q.push_back(d[w]);
            wl_q.push_back(~en[w]);
         end
      end
      if (!wr) begin
         rd_exp_q.push_back(e);
         rd_cyc_q.push_back(cyc);
      end
   endtask

   // Read answers: latency and the four words of the burst
   always @(negedge clk) begin
      if (rsp_valid === 1'b1) begin
         if (rd_exp_q.size() == 0) begin
            chk("unexpected answer", 1'b1, 1'b0);
         end else begin
            chk("read latency", DQ_W'(cyc - rd_cyc_q.pop_front()), DQ_W'(RD_LAT));
            exp_b = rd_exp_q.pop_front();
            for (int w = 0; w < 4; w++) begin
               chk("read word", rsp_rdata[w], exp_b[w]);
            end
         end
      end
   end

   // Write words and lanes as they cross the wire, in burst order
   always @(posedge i_dbs_link_if.k or posedge i_dbs_link_if.k_n) begin
      if (i_dbs_link_if.ctl_dq_oe === 1'b1 && wd_q.size() == 0) begin
         chk("spare write word", DQ_W'(1), DQ_W'(0));
      end else if (i_dbs_link_if.ctl_dq_oe === 1'b1) begin
         chk("bus write word", i_dbs_link_if.dq, wd_q.pop_front());
         chk("bus lanes", DQ_W'(i_dbs_link_if.byte_lane_write_n),
             DQ_W'(wl_q.pop_front()));
      end
   end

   // Hang guard over the whole run
   initial begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      clk = 1'b0;
      reset = 1'b1;
      dev_reset = 1'b1;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = '0;
      req_wdata = '0;
      req_wen = '0;
      error_cnt = 0;
      n_tests = 0;
      void'($urandom(32'h730A2625));
      repeat (10) @(negedge clk);
      reset = 1'b0;
      // Memory reset needs the link clock running for three rises
      repeat (16) @(negedge clk);
      dev_reset = 1'b0;
      repeat (16) @(negedge clk);
      // Array has no reset: fill every burst first
      for (int n = 0; n < 2 ** SA_W; n++) begin
         issue(1'b1, SA_W'(n), rnd_b(), '1);
      end
      issue(1'b1, 6'h05, rnd_b(), {4{4'h5}});
      issue(1'b1, 6'h06, rnd_b(), {4'hF, 4'h0, 4'hA, 4'h3});
      issue(1'b0, 6'h05, rnd_b(), '0);
      issue(1'b0, 6'h06, rnd_b(), '0);
      issue(1'b1, 6'h3F, rnd_b(), '0);
      issue(1'b0, 6'h3F, rnd_b(), '0);
      issue(1'b0, 6'h00, rnd_b(), '0);
      issue(1'b1, 6'h00, rnd_b(), '1);
      issue(1'b0, 6'h00, rnd_b(), '0);
      for (int n = 0; n < 300; n++) begin
         repeat ($urandom_range(12, 0)) @(negedge clk);
         issue(1'($urandom_range(1, 0)), SA_W'($urandom()), rnd_b(), 16'($urandom()));
      end
      // Drain both outstanding read answers and write words still to cross the wire
      for (int j = 0; j < 100 && (rd_exp_q.size() > 0 || wd_q.size() > 0); j++) begin
         @(negedge clk);
      end
      if (rd_exp_q.size() > 0 || wd_q.size() > 0) begin
         error_cnt++;
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
